// ===== rtl/wait_gen_params.svh
// Register offsets, field positions, reset values and widths for the wait-state generator
`ifndef WAIT_GEN_PARAMS_SVH
`define WAIT_GEN_PARAMS_SVH

`define WCC_OFFSET      7'h28
`define WMC_OFFSET      7'h2B
`define RANGE_SEL_BIT   15
`define IO_MSB          14
`define IO_LSB          12
`define DHI_MSB         11
`define DHI_LSB         9
`define DLO_MSB         8
`define DLO_LSB         6
`define PHI_MSB         5
`define PHI_LSB         3
`define PLO_MSB         2
`define PLO_LSB         0
`define DOUBLE_BIT      0
`define DATA_HALF_BIT   15
`define PAGE_HALF_BIT   15
`define EXT_HALF_BIT    22
`define FIELD_COUNT     5
`define FIELD_WIDTH     3
`define WCC_RESET       16'h7FFF
`define WMC_RESET       1'h0
`define ZERO_WAIT       4'h0

`endif

// ===== rtl/wait_gen_pkg.sv
// Types shared by the wait-state generator files
package wait_gen_pkg;

    typedef enum logic [1:0] {
        SPACE_PROG,
        SPACE_DATA,
        SPACE_IO
    } space_t;

    typedef struct packed {
        logic        start;
        space_t      space;
        logic [22:0] addr;
    } ext_req_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [6:0]  addr;
        logic [15:0] wdata;
    } cpu_req_t;

endpackage

// ===== rtl/wait_counter.sv
// Down counter that stretches one bus cycle, held at zero while gated
`timescale 1ns/1ps
`include "wait_gen_params.svh"
module wait_counter #(
    parameter int CW = 4
) (
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          reset_n,
    input  wire logic          gate_on,
    // Cycle control
    input  wire logic          load,
    input  wire logic [CW-1:0] count,
    input  wire logic          ready,
    output logic               busy
);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          act_r;
    logic          act_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        act_nxt = act_r;
        if (load) begin
            // Start cycle is the first wait, so one less is loaded
            cnt_nxt = (count == '0) ? '0 : count - CW'(1);
            act_nxt = 1'b1;
        end else if (act_r) begin
            if (cnt_r != '0) begin
                cnt_nxt = cnt_r - CW'(1);
            end else if (ready) begin
                act_nxt = 1'b0;
            end
        end
        if (!gate_on) begin
            // Gated: every count is zero, and no stale count may survive
            cnt_nxt = '0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= '0;
            act_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            act_r <= act_nxt;
        end
    end

    // Ready is only honoured once programmed waits have run out
    assign busy = act_r && ((cnt_r != '0) || !ready);
endmodule

// ===== rtl/wait_state_gen.sv
// Software-programmable wait-state generator for the external bus
//
// Notes on behaviour
// - Each external cycle is stretched by zero to fourteen software-selected waits.
// - Slow parts hold ready low; the cycle extends until ready is high.
// - When every region is zero waits, the counter clock is gated off.
// - Reset gives seven waits in every region, all fields ones.
// - Bits 14..12 hold the I/O space base count.
// - Bits 11..9 hold the upper data half base count.
// - Bits 8..6 hold the lower data half base count.
// - Bits 5..3 hold the upper program region count, split by range select.
// - Bits 2..0 hold the lower program region count, split by range select.
// - Bit 15 selects extended program range decoding; resets to zero.
// - Doubling bit set doubles every count, fourteen at most; resets zero.
// - Upper fifteen bits of the multiplier control read zero, ignore writes.
`timescale 1ns/1ps
`include "wait_gen_params.svh"
module wait_state_gen
    import wait_gen_pkg::*;
#(
    parameter int AW = 23
) (
    // Clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   reset_n,
    // Register port of the processor core
    input  wire wait_gen_pkg::cpu_req_t cpu,
    output logic [15:0]                 cpu_rdata,
    // External access request and ready
    input  wire wait_gen_pkg::ext_req_t ext,
    input  wire logic                   ready,
    output logic                        bus_hold,
    output logic                        clk_gate_on
);
    import wait_gen_pkg::*;

    // Four bits hold the doubled maximum of fourteen
    localparam int CW = 4;

    // ============================================================
    // Register strobes
    logic cfg_wr;
    logic cfg_rd;
    logic ctl_wr;
    logic ctl_rd;

    // One address compare shared by all four strobes
    function automatic logic addr_hit(input logic [6:0] addr,
                                      input logic [6:0] offset);
        addr_hit = (addr == offset);
    endfunction

    assign cfg_wr = cpu.wr && addr_hit(cpu.addr, `WCC_OFFSET);
    assign cfg_rd = cpu.rd && addr_hit(cpu.addr, `WCC_OFFSET);
    assign ctl_wr = cpu.wr && addr_hit(cpu.addr, `WMC_OFFSET);
    assign ctl_rd = cpu.rd && addr_hit(cpu.addr, `WMC_OFFSET);

    // ============================================================
    // Wait count configuration register
    logic [15:0] wcc_r;
    logic [15:0] wcc_nxt;

    always_comb begin
        wcc_nxt = wcc_r;
        if (cfg_wr) begin
            // Range select and all five count fields are writable
            wcc_nxt = cpu.wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wcc_r <= `WCC_RESET;
        end else begin
            wcc_r <= wcc_nxt;
        end
    end

    // ============================================================
    // Wait multiplier control register
    logic dbl_r;
    logic dbl_nxt;

    always_comb begin
        dbl_nxt = dbl_r;
        if (ctl_wr) begin
            // Only the doubling bit is stored; the rest of the word is dropped
            dbl_nxt = cpu.wdata[`DOUBLE_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dbl_r <= `WMC_RESET;
        end else begin
            dbl_r <= dbl_nxt;
        end
    end

    // ============================================================
    // Read data
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;

    always_comb begin
        rdata_nxt = rdata_r;
        if (cfg_rd) begin
            rdata_nxt = wcc_r;
        end else if (ctl_rd) begin
            rdata_nxt = {15'h0000, dbl_r};
        end else if (cpu.rd) begin
            // Unmapped offsets read as zero
            rdata_nxt = 16'h0000;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Held until the next read, so the core may sample late
    assign cpu_rdata = rdata_r;

    // ============================================================
    // Region decode
    // Three-bit count field whose lowest bit sits at lsb
    function automatic logic [2:0] field_at(input logic [15:0] cfg,
                                            input int          lsb);
        field_at = cfg[lsb +: `FIELD_WIDTH];
    endfunction

    function automatic logic [2:0] base_count(input logic [15:0]   cfg,
                                              input space_t        sp,
                                              input logic [AW-1:0] a);
        logic up;
        up = 1'b0;
        unique case (sp)
            SPACE_IO: begin
                base_count = field_at(cfg, `IO_LSB);
            end
            SPACE_DATA: begin
                if (a[`DATA_HALF_BIT]) begin
                    base_count = field_at(cfg, `DHI_LSB);
                end else begin
                    base_count = field_at(cfg, `DLO_LSB);
                end
            end
            default: begin
                // Range select picks page-half or whole-space split
                if (cfg[`RANGE_SEL_BIT]) begin
                    up = a[`EXT_HALF_BIT];
                end else begin
                    up = a[`PAGE_HALF_BIT];
                end
                if (up) begin
                    base_count = field_at(cfg, `PHI_LSB);
                end else begin
                    base_count = field_at(cfg, `PLO_LSB);
                end
            end
        endcase
    endfunction

    // Doubling by shift keeps the maximum at fourteen
    function automatic logic [CW-1:0] scale(input logic [2:0] b,
                                            input logic       dbl);
        if (dbl) begin
            scale = CW'({b, 1'b0});
        end else begin
            scale = CW'({1'b0, b});
        end
    endfunction

    logic [2:0]    base;
    logic [CW-1:0] waits;

    assign base  = base_count(wcc_r, ext.space, ext.addr[AW-1:0]);
    assign waits = scale(base, dbl_r);

    // ============================================================
    // Clock gating
    logic any_waits;

    always_comb begin
        any_waits = 1'b0;
        for (int f = 0; f < `FIELD_COUNT; f++) begin
            if (field_at(wcc_r, `FIELD_WIDTH * f) != 3'h0) begin
                any_waits = 1'b1;
            end
        end
    end

    // Bit 15 is no count, so range select alone leaves the clock off
    assign clk_gate_on = any_waits;

    // ============================================================
    // Wait counter
    logic cnt_busy;
    logic start_hold;

    // Every start reloads; the core starts no access while held
    wait_counter #(
        .CW (CW)
    ) u_cnt (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .gate_on (clk_gate_on),
        .load    (ext.start),
        .count   (waits),
        .ready   (ready),
        .busy    (cnt_busy)
    );

    // Start cycle holds if any waits are due or ready is low
    assign start_hold = ext.start && ((waits != `ZERO_WAIT) || !ready);

    // Ready is honoured even when gated, so slow parts still work
    assign bus_hold = cnt_busy || start_hold;
endmodule

// ===== sim/wait_gen_chk.sv
// Port checker for the wait-state generator
`timescale 1ns/1ps
`include "wait_gen_params.svh"
module wait_gen_chk
    import wait_gen_pkg::*;
(
    // Clock and reset
    input logic clk_sys,
    input logic reset_n,
    // Watched ports
    input cpu_req_t cpu,
    input logic [15:0] cpu_rdata,
    input ext_req_t ext,
    input logic ready,
    input logic bus_hold,
    input logic clk_gate_on
);
    logic [15:0] c_r;
    logic d_r;
    logic [3:0] r_r;
    logic [3:0] w;
    logic [2:0] b;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    always_comb begin
        case (ext.space)
            SPACE_IO: b = c_r[14:12];
            SPACE_DATA: b = ext.addr[15] ? c_r[11:9] : c_r[8:6];
            default: b = (c_r[15] ? ext.addr[22] : ext.addr[15]) ? c_r[5:3] : c_r[2:0];
        endcase
        w = d_r ? {b, 1'h0} : {1'h0, b};
    end
    // Shadow registers; the start cycle is the first wait
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            c_r <= `WCC_RESET;
            d_r <= 1'h0;
            r_r <= 4'h0;
        end else begin
            if (cpu.wr && cpu.addr == `WCC_OFFSET) c_r <= cpu.wdata;
            if (cpu.wr && cpu.addr == `WMC_OFFSET) d_r <= cpu.wdata[0];
            if (ext.start) r_r <= (w == 4'h0) ? 4'h0 : w - 4'h1;
            else if (r_r != 4'h0) r_r <= r_r - 4'h1;
        end
    end
    gate_on_a: assert property (clk_gate_on == (c_r[14:0] != 15'h0))
        else $error("gate");
    start_hold_a: assert property (ext.start && w != 4'h0 |-> bus_hold)
        else $error("start");
    zero_wait_a: assert property (ext.start && w == 4'h0 && ready |-> !bus_hold)
        else $error("zero");
    count_hold_a: assert property (r_r != 4'h0 |-> bus_hold)
        else $error("count");
    hold_end_a: assert property (r_r == 4'h0 && ready && !ext.start |-> !bus_hold)
        else $error("end");
    ready_ext_a: assert property ($past(bus_hold) && !ready && !ext.start |-> bus_hold)
        else $error("ready");
    cfg_read_a: assert property (cpu.rd && cpu.addr == `WCC_OFFSET |=> cpu_rdata == c_r)
        else $error("cfg");
    ctl_read_a: assert property (cpu.rd && cpu.addr == `WMC_OFFSET |=>
        cpu_rdata == {15'h0, d_r}) else $error("ctl");
endmodule

// ===== sim/ext_bus_model.sv
// Slow external part that holds ready low
`timescale 1ns/1ps
module ext_bus_model (
    // Clock and reset
    input logic clk_sys,
    input logic reset_n,
    // Bus side
    input logic start,
    input logic [3:0] slow,
    output logic ready
);
    logic [3:0] n_r;
    // Pulled up when idle
    assign ready = start ? (slow == 4'h0) : (n_r == 4'h0);
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) n_r <= 4'h0;
        else if (start) n_r <= (slow == 4'h0) ? 4'h0 : slow - 4'h1;
        else if (n_r != 4'h0) n_r <= n_r - 4'h1;
    end
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the wait-state generator
`timescale 1ns/1ps
`include "wait_gen_params.svh"
module testbench;
    import wait_gen_pkg::*;
    logic clk_sys, reset_n, ready, bus_hold, clk_gate_on;
    cpu_req_t cpu;
    ext_req_t ext;
    logic [15:0] cpu_rdata;
    logic [3:0] slow;
    int error_cnt, comparisons;
    wait_state_gen dut_u (.clk_sys, .reset_n, .cpu, .cpu_rdata, .ext, .ready, .bus_hold,
        .clk_gate_on);
    ext_bus_model far_u (.clk_sys, .reset_n, .start(ext.start), .slow, .ready);
    initial begin
        clk_sys = 1'h0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge clk_sys) #1 cpu = '{1'h1, 1'h0, a, d};
        @(posedge clk_sys) #1 cpu.wr = 1'h0;
    endtask
    task rd(input logic [6:0] a, input logic [15:0] e);
        @(posedge clk_sys) #1 cpu = '{1'h0, 1'h1, a, 16'h0};
        @(posedge clk_sys) #1 cpu.rd = 1'h0;
        chk(cpu_rdata, e);
    endtask
    // Counts held cycles over a fixed window, longer than any legal stretch
    task acc(input space_t s, input logic [22:0] a, input int e);
        int n;
        n = 0;
        @(posedge clk_sys) #1 ext = '{1'h1, s, a};
        repeat (20) begin
            #1 if (bus_hold === 1'h1) n++;
            @(posedge clk_sys) #1 ext.start = 1'h0;
        end
        chk(16'(n), 16'(e));
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #20000;
        error_cnt++;
        summarize;
    end
    initial begin
        {reset_n, cpu, ext, slow, error_cnt, comparisons} = '0;
        repeat (6) @(posedge clk_sys);
        #1 reset_n = 1'h1;
        rd(`WCC_OFFSET, `WCC_RESET);
        rd(`WMC_OFFSET, 16'h0);
        chk({15'h0, clk_gate_on}, 16'h1);
        acc(SPACE_IO, 23'h0, 7);
        wr(`WMC_OFFSET, 16'hFFFF);
        rd(`WMC_OFFSET, 16'h1);
        acc(SPACE_IO, 23'hFFFF, 14);
        rd(7'h2A, 16'h0);
        $display("test reset done");
        for (int x = 0; x < 2; x++) begin
            wr(`WCC_OFFSET, {x[0], 15'h14E5});
            for (int m = 1; m < 3; m++) begin
                wr(`WMC_OFFSET, {15'h0, m == 2});
                acc(SPACE_IO, 23'h1234, m);
                acc(SPACE_DATA, 23'h8000, 2 * m);
                acc(SPACE_DATA, 23'h7FFF, 3 * m);
                acc(SPACE_PROG, x ? 23'h400000 : 23'h018000, 4 * m);
                acc(SPACE_PROG, x ? 23'h3F8000 : 23'h017FFF, 5 * m);
            end
        end
        $display("test regions done");
        wr(`WCC_OFFSET, 16'h0);
        chk({15'h0, clk_gate_on}, 16'h0);
        acc(SPACE_PROG, 23'h0, 0);
        slow = 4'h3;
        acc(SPACE_PROG, 23'h0, 3);
        wr(`WCC_OFFSET, 16'h1000);
        slow = 4'h5;
        acc(SPACE_IO, 23'h0, 5);
        $display("test ready done");
        summarize;
    end
endmodule
bind wait_state_gen wait_gen_chk chk_u (.clk_sys, .reset_n, .cpu, .cpu_rdata, .ext, .ready,
    .bus_hold, .clk_gate_on);
